/* hw/adpcm_tdm_channel_port.sv */
// Serial TDM data port and per-sample control of one ADPCM channel.
// Function
// RULE_01 - PCM words are 8 bits, ADPCM words 4 bits, for every rate.
// RULE_02 - Bit after 24 kbit/s code LSB is 1 only in software 24k compression.
// RULE_03 - Software mode places no restriction on the output slot.
// RULE_04 - Capture-to-output latency stays below 375 microseconds.
// RULE_05 - While at 32 kbit/s, frame sync is watched for a double-width pulse.
// RULE_06 - A double-width pulse switches processing from 32 to 24 kbit/s.
// RULE_07 - Outside framing may put signaling into the code LSB in such frames.
// RULE_08 - Control register is fetched before each sample; changes apply next sample.
// RULE_09 - Host finishes a new selection before the first sample using it.
// RULE_10 - Serial output goes high impedance during a control update.
// RULE_11 - Frame sync is one bit period wide except in signaling frames.
// RULE_12 - Output is released after the LSB of each word.
// RULE_13 - Master clock is 10 MHz within 500 ppm.
// RULE_14 - Control port accepts either shift clock idle level at chip select.
// RULE_15 - Slot counting starts at first rising bit clock after frame sync.
// RULE_16 - Coding direction 0 decodes, 1 encodes, choosing word widths per side.
// RULE_17 - Hardware mode fixes input and output slots at zero.
// RULE_18 - Double width means frame sync high for two consecutive bit periods.
// RULE_19 - A single-width frame sync returns the channel to 32 kbit/s.
module adpcm_tdm_channel_port
    import adpcm_tdm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic bitClockChanA,
    input wire logic frameSyncChanA,
    input wire logic serialInChanA,
    output logic serialOutChanA,
    output logic serialOutEnChanA,
    input wire logic ctrlShiftClk,
    input wire logic ctrlChipSelN,
    input wire logic ctrlSerialIn,
    input wire logic portModeStrap,
    input wire logic codingDirection,
    input wire logic rateSelect0,
    input wire logic rateSelect1,
    input wire logic rateSelect2,
    input wire logic idleSelect,
    input wire logic [SLOT_W-1:0] inputSlot,
    input wire logic [SLOT_W-1:0] outputSlot,
    input wire logic [PCM_BITS-1:0] resultWord,
    output logic [PCM_BITS-1:0] sampleWord,
    output logic sampleValid,
    output rate_t activeRate,
    output logic signalingFrame,
    output ctrl_t frameCtrl
);
    // ------------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------------
    logic [11:0] pinS;
    logic clkS, fsS, sinS, sclkS, csnS, sdiS, swMode, dirS, rs0S, rs1S, rs2S, idleS;

    adpcm_tdm_sync #(.WIDTH(12)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async({bitClockChanA, frameSyncChanA, serialInChanA, ctrlShiftClk, ctrlChipSelN,
                ctrlSerialIn, portModeStrap, codingDirection, rateSelect0, rateSelect1,
                rateSelect2, idleSelect}),
        .synced(pinS)
    );

    assign {clkS, fsS, sinS, sclkS, csnS, sdiS, swMode, dirS, rs0S, rs1S, rs2S, idleS} = pinS;

    logic clkPrev_q, sclkPrev_q, csnPrev_q;
    logic bitRise, bitFall, sclkRise, csRelease, csBusy;

    assign bitRise = clkS & ~clkPrev_q;
    assign bitFall = ~clkS & clkPrev_q;
    assign sclkRise = sclkS & ~sclkPrev_q;
    assign csRelease = csnS & ~csnPrev_q;
    assign csBusy = swMode & ~csnS;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clkPrev_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            csnPrev_q <= 1'b1;
        end else begin
            clkPrev_q <= clkS;
            sclkPrev_q <= sclkS;
            csnPrev_q <= csnS;
        end
    end

    // ------------------------------------------------------------------------
    // Serial control port
    // ------------------------------------------------------------------------
    ctrl_t ctrlReg_q, ctrlReg_d;
    logic [CTRL_BITS-1:0] ctrlShift_q, ctrlShift_d;
    logic [3:0] ctrlCnt_q, ctrlCnt_d;

    always_comb begin
        ctrlReg_d = ctrlReg_q;
        ctrlShift_d = ctrlShift_q;
        ctrlCnt_d = ctrlCnt_q;
        if (!swMode) begin
            ctrlReg_d = CTRL_RESET;
            ctrlCnt_d = '0;
        end else if (!csnS) begin
            // Shift clock edges only count while selected, so its idle level is irrelevant.
            if (sclkRise) begin // [RULE_14]
                ctrlShift_d = {ctrlShift_q[CTRL_BITS-2:0], sdiS};
                ctrlCnt_d = (ctrlCnt_q == CTRL_FULL) ? CTRL_FULL : ctrlCnt_q + 4'h1;
            end
        end else begin
            if (csRelease && ctrlCnt_q == CTRL_FULL) begin
                ctrlReg_d = ctrlShift_q;
            end
            ctrlCnt_d = '0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlReg_q <= CTRL_RESET;
            ctrlShift_q <= '0;
            ctrlCnt_q <= '0;
        end else begin
            ctrlReg_q <= ctrlReg_d;
            ctrlShift_q <= ctrlShift_d;
            ctrlCnt_q <= ctrlCnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Effective control and slot geometry
    // ------------------------------------------------------------------------
    function automatic rate_t decodeRate(input ctrl_t c);
        logic [2:0] sel;
        sel = {c.rateSelect2, c.rateSelect1, c.rateSelect0};
        case (sel)
            RATE_SEL_24: decodeRate = RATE_24;
            RATE_SEL_16: decodeRate = RATE_16;
            default: decodeRate = RATE_32;
        endcase
    endfunction : decodeRate

    ctrl_t pinCtrl, effCtrl;
    logic [SLOT_W-1:0] inSlot, outSlot;
    logic [CNT_W-1:0] inStart, outStart, inLast, outLast, outIdx;
    logic [2:0] codeBits;
    link_t link_q, link_d;
    ctrl_t frameCtrl_q, frameCtrl_d;
    logic [CNT_W-1:0] bitCnt_q, bitCnt_d;
    logic fsRun_q, fsRun_d, casFrame_q, casFrame_d, padOne_q, padOne_d;
    logic [PCM_BITS-1:0] inShift_q, inShift_d, sampleWord_q, sampleWord_d;
    logic sampleValid_q, sampleValid_d, serialOut_q, serialOut_d, outEn_q, outEn_d;
    rate_t activeRate_q, activeRate_d;

    always_comb begin
        pinCtrl = CTRL_RESET;
        pinCtrl.codingDirection = dirS;
        pinCtrl.idle = idleS;
        pinCtrl.rateSelect0 = rs0S;
        pinCtrl.rateSelect1 = rs1S;
        pinCtrl.rateSelect2 = rs2S;
    end

    assign effCtrl = swMode ? ctrlReg_q : pinCtrl;
    // Hardware mode pins both slots to zero; software mode allows any output slot.
    assign inSlot = swMode ? inputSlot : HW_SLOT; // [RULE_17]
    assign outSlot = swMode ? outputSlot : HW_SLOT; // [RULE_17] [RULE_03]

    // Encoding takes 8-bit PCM in and gives 4-bit codes out; decoding the reverse.
    always_comb begin // [RULE_16] [RULE_01]
        if (frameCtrl_q.codingDirection) begin
            inStart = {1'b0, inSlot, 3'h0};
            inLast = inStart + PCM_LAST;
            outStart = {2'h0, outSlot, 2'h0};
            outLast = outStart + ADPCM_LAST;
        end else begin
            inStart = {2'h0, inSlot, 2'h0};
            inLast = inStart + ADPCM_LAST;
            outStart = {1'b0, outSlot, 3'h0};
            outLast = outStart + PCM_LAST;
        end
        outIdx = bitCnt_q - outStart;
        case (activeRate_q)
            RATE_24: codeBits = CODE_BITS_24;
            RATE_16: codeBits = CODE_BITS_16;
            default: codeBits = CODE_BITS_32;
        endcase
    end

    // ------------------------------------------------------------------------
    // Frame timing, capture and output
    // ------------------------------------------------------------------------
    always_comb begin
        link_d = link_q;
        frameCtrl_d = frameCtrl_q;
        bitCnt_d = bitCnt_q;
        fsRun_d = fsRun_q;
        casFrame_d = casFrame_q;
        padOne_d = padOne_q;
        inShift_d = inShift_q;
        sampleWord_d = sampleWord_q;
        sampleValid_d = 1'b0;
        serialOut_d = serialOut_q;
        outEn_d = outEn_q;
        if (bitFall) begin
            fsRun_d = fsS;
            if (fsS) begin
                bitCnt_d = '0; // [RULE_15]
                inShift_d = '0;
                link_d = LINK_RUN;
                if (fsRun_q) begin
                    casFrame_d = 1'b1; // [RULE_18] [RULE_05]
                end else begin
                    casFrame_d = 1'b0; // [RULE_19]
                    frameCtrl_d = effCtrl; // [RULE_08]
                    padOne_d = swMode && effCtrl.codingDirection
                        && decodeRate(effCtrl) == RATE_24; // [RULE_02]
                end
            end else if (link_q == LINK_RUN) begin
                if (bitCnt_q >= inStart && bitCnt_q <= inLast) begin
                    inShift_d = {inShift_q[PCM_BITS-2:0], sinS};
                    if (bitCnt_q == inLast) begin
                        sampleWord_d = inShift_d;
                        sampleValid_d = 1'b1;
                    end
                end
                bitCnt_d = (bitCnt_q == CNT_MAX) ? CNT_MAX : bitCnt_q + 10'h001;
            end
        end
        if (bitRise) begin
            if (link_q == LINK_RUN && !frameCtrl_q.idle
                && bitCnt_q >= outStart && bitCnt_q <= outLast) begin
                outEn_d = 1'b1;
                if (frameCtrl_q.codingDirection && outIdx >= {7'h00, codeBits}) begin
                    serialOut_d = padOne_q && outIdx == {7'h00, codeBits}; // [RULE_02]
                end else begin
                    serialOut_d = resultWord[3'(PCM_BITS - 1) - outIdx[2:0]];
                end
            end else begin
                outEn_d = 1'b0; // [RULE_12]
                serialOut_d = 1'b0;
            end
        end
        if (csBusy) begin
            outEn_d = 1'b0; // [RULE_10]
        end
        // A double-width pulse in a 32 kbit/s frame runs the 24 kbit/s algorithm.
        activeRate_d = decodeRate(frameCtrl_q);
        if (casFrame_q && activeRate_d == RATE_32) begin
            activeRate_d = RATE_24; // [RULE_06]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            link_q <= LINK_WAIT;
            frameCtrl_q <= CTRL_RESET;
            bitCnt_q <= '0;
            fsRun_q <= 1'b0;
            casFrame_q <= 1'b0;
            padOne_q <= 1'b0;
            inShift_q <= '0;
            sampleWord_q <= '0;
            sampleValid_q <= 1'b0;
            serialOut_q <= 1'b0;
            outEn_q <= 1'b0;
            activeRate_q <= RATE_32;
        end else begin
            link_q <= link_d;
            frameCtrl_q <= frameCtrl_d;
            bitCnt_q <= bitCnt_d;
            fsRun_q <= fsRun_d;
            casFrame_q <= casFrame_d;
            padOne_q <= padOne_d;
            inShift_q <= inShift_d;
            sampleWord_q <= sampleWord_d;
            sampleValid_q <= sampleValid_d;
            serialOut_q <= serialOut_d;
            outEn_q <= outEn_d;
            activeRate_q <= activeRate_d;
        end
    end

    assign serialOutChanA = serialOut_q;
    assign serialOutEnChanA = outEn_q;
    assign sampleWord = sampleWord_q;
    assign sampleValid = sampleValid_q;
    assign activeRate = activeRate_q;
    assign signalingFrame = casFrame_q;
    assign frameCtrl = frameCtrl_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic [11:0] latCnt_q;
    logic latRun_q;

    // Measures core cycles from a captured sample to the next driven output bit.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            latCnt_q <= '0;
            latRun_q <= 1'b0;
        end else if (sampleValid_q && !latRun_q) begin
            latCnt_q <= '0;
            latRun_q <= 1'b1;
        end else if (latRun_q && (outEn_q || frameCtrl_q.idle || csBusy)) begin
            latRun_q <= 1'b0;
        end else if (latRun_q && latCnt_q != LAT_LIMIT) begin
            latCnt_q <= latCnt_q + 12'h001;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_busy_tristate: assert property (csBusy |=> !serialOutEnChanA) // [RULE_10]
        else $error("output driven during control update");
    a_release_after_lsb: assert property ( // [RULE_12]
        bitRise && !csBusy && bitCnt_q == outLast + 10'h001 |=> !serialOutEnChanA)
        else $error("output not released after word LSB");
    a_hw_slot_zero: assert property (!swMode && bitRise && link_q == LINK_RUN // [RULE_17]
        && bitCnt_q == '0 && !frameCtrl_q.idle |=> serialOutEnChanA)
        else $error("hardware mode not driving slot zero");
    a_cas_detect: assert property (bitFall && fsS && fsRun_q |=> casFrame_q) // [RULE_18]
        else $error("double-width frame sync not detected");
    a_cas_return: assert property (bitFall && fsS && !fsRun_q |=> !casFrame_q) // [RULE_19]
        else $error("single-width frame sync did not end signaling");
    a_cas_rate_switch: assert property (casFrame_q // [RULE_06]
        && decodeRate(frameCtrl_q) == RATE_32 |=> activeRate == RATE_24)
        else $error("signaling frame not run at 24 kbit/s");
    a_ctrl_fetch: assert property (bitFall && fsS && !fsRun_q // [RULE_08]
        |=> frameCtrl == $past(effCtrl))
        else $error("control not fetched at frame start");
    a_count_start: assert property (bitFall && fsS // [RULE_15]
        |=> bitCnt_q == '0 ##0 link_q == LINK_RUN)
        else $error("slot count not restarted by frame sync");
    a_ctrl_load: assert property (swMode && csRelease && ctrlCnt_q == CTRL_FULL // [RULE_14]
        |=> ctrlReg_q == $past(ctrlShift_q))
        else $error("control word not loaded at deselect");
    a_latency_bound: assert property (latCnt_q < LAT_LIMIT) // [RULE_04]
        else $error("sample to output latency too long");
endmodule : adpcm_tdm_channel_port

/* hw/adpcm_tdm_pkg.sv */
// Shared constants and types of the TDM channel port, and its input synchroniser.

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package adpcm_tdm_pkg;
    localparam int PCM_BITS = 8;
    localparam int ADPCM_BITS = 4;
    localparam int CNT_W = 10;
    localparam int SLOT_W = 6;
    localparam int CTRL_BITS = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
    localparam logic [CNT_W-1:0] PCM_LAST = 10'h007;
    localparam logic [CNT_W-1:0] ADPCM_LAST = 10'h003;
    localparam logic [SLOT_W-1:0] HW_SLOT = 6'h00;
    localparam logic [3:0] CTRL_FULL = 4'h8;
    localparam logic [2:0] RATE_SEL_32 = 3'h0;
    localparam logic [2:0] RATE_SEL_24 = 3'h7;
    localparam logic [2:0] RATE_SEL_16 = 3'h5;
    localparam logic [2:0] CODE_BITS_32 = 3'h4;
    localparam logic [2:0] CODE_BITS_24 = 3'h3;
    localparam logic [2:0] CODE_BITS_16 = 3'h2;
    localparam int LATENCY_US = 375;
    localparam int CORE_CLK_MHZ = 10;
    localparam int LATENCY_CYCLES = LATENCY_US * CORE_CLK_MHZ;
    localparam logic [11:0] LAT_LIMIT = 12'(LATENCY_CYCLES);

    typedef enum logic [1:0] {RATE_32, RATE_24, RATE_16} rate_t;
    typedef enum logic {LINK_WAIT, LINK_RUN} link_t;

    // Control word, most significant bit first as it is shifted in.
    typedef struct packed {
        logic rateSelect0;
        logic rateSelect1;
        logic idle;
        logic algReset;
        logic bypass;
        logic muLaw;
        logic rateSelect2;
        logic codingDirection;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = 8'h00;
endpackage : adpcm_tdm_pkg

// ----------------------------------------------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------------------------------------------
module adpcm_tdm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1_q;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                stage1_q[i] <= 1'b0;
                synced[i] <= 1'b0;
            end else begin
                stage1_q[i] <= async[i];
                synced[i] <= stage1_q[i];
            end
        end
    end
endmodule : adpcm_tdm_sync

/* verif/tdm_far_end_model.sv */
// Far-end TDM link model: bit clock, frame sync, serial data in and output capture.

// ----------------------------------------------------------------------------
// Link model
// ----------------------------------------------------------------------------
module tdm_far_end_model (
    output logic bitClk,
    output logic fsync,
    output logic sIn,
    input wire logic sOut,
    input wire logic sOutEn,
    output logic [16:0] outBits,
    output logic [16:0] enBits,
    output logic doneTgl
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        bitClk = 1'b1;
        fsync = 1'b0;
        sIn = 1'b0;
        outBits = '0;
        enBits = '0;
        doneTgl = 1'b0;
    end

    // The clock stands high between frames and data toggles outside the word.
    // Each output bit is captured just before the rise that ends it.
    task automatic runFrame(input logic dbl, input logic [7:0] word, input int first,
                            input int nBits);
        int pos;
        #37;
        for (int k = 0; k < 18; k++) begin
            #200;
            fsync = (k == 0) || (dbl && k == 1);
            pos = k - 1 - first;
            sIn = (pos >= 0 && pos < nBits) ? word[7-pos] : ~sIn;
            #200;
            bitClk = 1'b0;
            #400;
            if (k > 0) begin
                outBits[k-1] = sOut;
                enBits[k-1] = sOutEn;
            end
            bitClk = 1'b1;
        end
        doneTgl = ~doneTgl;
    endtask : runFrame
endmodule : tdm_far_end_model

/* verif/adpcm_tdm_channel_port_test.sv */
// Self-checking bench of the TDM channel port.

// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module adpcm_tdm_channel_port_test
    import adpcm_tdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic sw; logic dir; logic [2:0] rsel; logic dbl; logic idle;
        logic [SLOT_W-1:0] inSlot; logic [SLOT_W-1:0] outSlot;
    } case_t;
    typedef struct packed {
        logic [16:0] out; logic [16:0] en; rate_t rate; logic sig; logic sw; ctrl_t ctrl;
    } exp_t;
    localparam case_t CASES [12] = '{
        '{0, 1, 0, 0, 0, 3, 5},
        '{0, 1, 7, 0, 0, 0, 0},
        '{0, 1, 0, 1, 0, 0, 0},
        '{0, 1, 0, 0, 0, 0, 0},
        '{0, 0, 5, 0, 0, 0, 0},
        '{0, 1, 0, 0, 1, 0, 0},
        '{1, 1, 7, 0, 0, 0, 0},
        '{1, 1, 5, 0, 0, 0, 0},
        '{1, 1, 0, 0, 1, 0, 0},
        '{1, 1, 0, 0, 0, 1, 2},
        '{1, 0, 7, 0, 0, 0, 0},
        '{1, 1, 0, 1, 0, 0, 0}
    };
    logic core_clk, rst, bitClk, fsync, sIn, sOut, sOutEn, sclk, csN, ctrlIn, strap, dir;
    logic idleSel, smpValid, sigFrame, doneTgl;
    logic [2:0] rsel;
    logic [SLOT_W-1:0] inSlot, outSlot;
    logic [PCM_BITS-1:0] res, smp;
    logic [16:0] outBits, enBits;
    logic [31:0] rng;
    rate_t rate;
    ctrl_t fCtrl;
    exp_t cur;
    exp_t expQ[$];
    logic [7:0] smpQ[$];
    int bad_count, n_compared, cycles;

    adpcm_tdm_channel_port uut (.core_clk(core_clk), .rst(rst), .bitClockChanA(bitClk),
        .frameSyncChanA(fsync), .serialInChanA(sIn), .serialOutChanA(sOut),
        .serialOutEnChanA(sOutEn), .ctrlShiftClk(sclk), .ctrlChipSelN(csN),
        .ctrlSerialIn(ctrlIn), .portModeStrap(strap), .codingDirection(dir),
        .rateSelect0(rsel[0]), .rateSelect1(rsel[1]), .rateSelect2(rsel[2]),
        .idleSelect(idleSel), .inputSlot(inSlot), .outputSlot(outSlot), .resultWord(res),
        .sampleWord(smp), .sampleValid(smpValid), .activeRate(rate),
        .signalingFrame(sigFrame), .frameCtrl(fCtrl));
    tdm_far_end_model far (.bitClk(bitClk), .fsync(fsync), .sIn(sIn), .sOut(sOut),
        .sOutEn(sOutEn), .outBits(outBits), .enBits(enBits), .doneTgl(doneTgl));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift

    task automatic check(input string what, input logic [16:0] want, input logic [16:0] got);
        n_compared++;
        if (got !== want) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, want, got);
        end
    endtask : check

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic ctrlWrite(input ctrl_t v, input logic idleHi);
        @(posedge core_clk) sclk <= idleHi;
        repeat (3) @(posedge core_clk);
        csN <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            repeat (5) @(posedge core_clk);
            sclk <= 1'b0;
            ctrlIn <= v[i];
            repeat (5) @(posedge core_clk);
            sclk <= 1'b1;
        end
        repeat (5) @(posedge core_clk);
        csN <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask : ctrlWrite

    // The direction and rate pins are inverted and the idle pin held low in software
    // mode so that a design that wrongly follows them there is caught.
    task automatic runCase(input case_t c, input logic idleHi);
        logic [7:0] w;
        logic [7:0] rw;
        ctrl_t cw;
        rate_t r;
        int cb, nOut, nIn, oSt, iSt;
        logic pad;
        exp_t e;
        rng = xorshift(rng);
        w = rng[7:0];
        rw = rng[15:8];
        cw = {c.rsel[0], c.rsel[1], c.idle, 3'h0, c.rsel[2], c.dir};
        @(posedge core_clk);
        strap <= c.sw;
        dir <= c.dir ^ c.sw;
        rsel <= c.rsel ^ {3{c.sw}};
        idleSel <= c.idle & !c.sw;
        inSlot <= c.inSlot;
        outSlot <= c.outSlot;
        res <= rw;
        if (c.sw) ctrlWrite(cw, idleHi);
        else repeat (8) @(posedge core_clk);
        if (c.rsel == RATE_SEL_24) r = RATE_24;
        else if (c.rsel == RATE_SEL_16) r = RATE_16;
        else r = c.dbl ? RATE_24 : RATE_32;
        cb = (r == RATE_32) ? 4 : (r == RATE_24) ? 3 : 2;
        pad = c.sw && c.rsel == RATE_SEL_24 && c.dir;
        nOut = c.dir ? ADPCM_BITS : PCM_BITS;
        nIn = c.dir ? PCM_BITS : ADPCM_BITS;
        oSt = (c.sw ? int'(c.outSlot) * nOut : 0) + c.dbl;
        iSt = (c.sw ? int'(c.inSlot) * nIn : 0) + c.dbl;
        e = '0;
        e.rate = r;
        e.sig = c.dbl;
        e.sw = c.sw;
        e.ctrl = cw;
        // The first rise of a double-width pulse already drives bit 0 before the restart.
        if (c.dbl && oSt == 1) begin
            e.en[0] = !c.idle;
            e.out[0] = rw[7];
        end
        for (int i = 0; i < nOut; i++) begin
            e.en[oSt+i] = !c.idle;
            // Code bits stay plain result bits, even the LSB that framing may overwrite.
            e.out[oSt+i] = (!c.dir || i < cb) ? rw[7-i] : (i == cb) && pad;
        end
        expQ.push_back(e);
        smpQ.push_back(c.dir ? w : {4'h0, w[7:4]});
        far.runFrame(c.dbl, w, iSt, nIn);
        repeat (4) @(posedge core_clk);
    endtask : runCase

    always @(doneTgl) begin
        if (rst === 1'b0) begin
            if (expQ.size() == 0) begin
                check("frame count", 17'h0, 17'h1);
            end else begin
                cur = expQ.pop_front();
                check("output enable", cur.en, enBits);
                check("output data", cur.out & cur.en, outBits & cur.en);
                check("active rate", 17'(cur.rate), 17'(rate));
                check("signaling frame", 17'(cur.sig), 17'(sigFrame));
                if (cur.sw) check("frame control", 17'(cur.ctrl), 17'(fCtrl));
            end
        end
    end

    always @(posedge core_clk) begin
        if (smpValid === 1'b1) begin
            if (smpQ.size() == 0) begin
                check("sample count", 17'h0, 17'h1);
            end else begin
                check("sample word", 17'(smpQ.pop_front()), 17'(smp));
            end
        end
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        rst = 1'b1;
        sclk = 1'b0;
        csN = 1'b1;
        ctrlIn = 1'b0;
        strap = 1'b0;
        dir = 1'b0;
        rsel = 3'h0;
        idleSel = 1'b0;
        inSlot = '0;
        outSlot = '0;
        res = '0;
        rng = 32'h16;
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        foreach (CASES[i]) runCase(CASES[i], i[0]);
        @(posedge core_clk) csN <= 1'b0;
        expQ.push_back('{out: '0, en: '0, rate: RATE_32, sig: 1'b0, sw: 1'b0, ctrl: '0});
        smpQ.push_back(8'h5a);
        far.runFrame(1'b0, 8'h5a, 0, 8);
        @(posedge core_clk) csN <= 1'b1;
        repeat (20) @(posedge core_clk);
        check("pending frames", 17'(expQ.size()), 17'h0);
        check("pending samples", 17'(smpQ.size()), 17'h0);
        close_out();
    end
endmodule : adpcm_tdm_channel_port_test
